// ### hw/sar_pkg.sv
`default_nettype none
package sar_pkg;

  // ***********************************************
  // mode register addresses
  // ***********************************************
  localparam logic [7:0] MA_BURST_CFG = 8'h01;
  localparam logic [7:0] MA_LATENCY_CFG = 8'h02;
  localparam logic [7:0] MA_BANK_MASK = 8'h10;
  localparam logic [7:0] MA_SEG_MASK = 8'h11;
  localparam logic [7:0] MA_CAL_A = 8'h20;
  localparam logic [7:0] MA_CAL_B = 8'h28;
  localparam logic [7:0] MA_SOFT_RESET = 8'h3F;

  // ***********************************************
  // field codes and values after reset
  // ***********************************************
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [2:0] RST_BL_CODE = BL_CODE_4;
  localparam logic [3:0] RL_CODE_MIN = 4'h1;
  localparam logic [3:0] RL_CODE_MAX = 4'h6;
  localparam logic [3:0] RL_CODE_OFS = 4'h2;
  localparam logic [3:0] RST_RL_CODE = 4'h1;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [3:0] RST_RD_GAP = 4'hF;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RPPB_NS = 18;
  localparam int T_RPAB_NS = 21;
  localparam logic [3:0] RPPB_CYC = 4'((T_RPPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RPAB_CYC = 4'((T_RPAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] T_CCD_CK = 4'h2;
  localparam int PIPE_DEPTH = 8;

  // ***********************************************
  // carriers
  // ***********************************************
  typedef struct packed {
    logic cs_n;
    logic [9:0] ca;
  } sar_cabus_s;

  typedef struct packed {
    logic valid;
    logic mrr;
    logic [2:0] bank;
    logic [14:0] row;
    logic [11:0] col;
    logic [7:0] mr_data;
  } sar_rd_s;

endpackage
`default_nettype wire

// ### hw/sar_device.sv
// Functional notes
// - activate: chip select low, CA0 low, CA1 high at clock rise
// - activate: BA0-BA2 pick the bank, R0-R14 pick the row opened
// - all-bank precharge takes tRPab, longer than tRPpb on eight banks
// - column command: CA0 high, CA1 low; CA2 high read, low write
// - burst 8/16: read cut by read, even cycles later, tCCD met
// - start column from CA5-CA6 on rise and CA1-CA9 on fall
// - read data starts read latency clocks after the read command
// - strobe low one preamble first, then each beat edge-aligned to strobe
// - gapless reads every 2, 4 or 8 clocks for burst 4, 8, 16
// - interrupted read length is twice the clocks between the two reads
// - segment mask bit set blocks self-refresh of that segment; write-only
// - segment n is rows whose bits R13 to R11 equal n
// - mode reads at 20H and 28H return calibration patterns A and B
// - mode write to 3FH resets the device, data ignored
// - bank mask bit set blocks self-refresh of that bank; 4 banks use 3:0
// - burst length code 010 gives 4, 011 gives 8, 100 gives 16
`default_nettype none
module sar_device
  import sar_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter logic [7:0] CAL_PATTERN_A = 8'h55,
  parameter logic [7:0] CAL_PATTERN_B = 8'h33
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // command clock and command/address pins
  input wire logic i_ck,
  input wire logic i_cs_n,
  input wire logic [9:0] i_ca,
  // data pins
  output logic [31:0] o_dq_out,
  output logic o_dq_oe,
  output logic o_dqs_out,
  output logic o_dqs_oe,
  // self-refresh masking query
  input wire logic [2:0] i_sr_bank,
  input wire logic [14:0] i_sr_row,
  output logic o_sr_blocked,
  // status
  output logic [7:0] o_bank_open,
  output logic o_proto_err,
  output logic o_soft_reset
);

  if (NUM_BANKS != 4 && NUM_BANKS != 8)
  begin : g_bad_banks
    $error("NUM_BANKS must be 4 or 8");
  end

  // ***********************************************
  // helpers
  // ***********************************************
  // four-bank parts ignore BA2
  function automatic logic [2:0] bank_of(input logic [2:0] ba);
    bank_of = (NUM_BANKS == 4) ? {1'b0, ba[1:0]} : ba;
  endfunction

  function automatic logic [4:0] beats_of(input logic [2:0] code);
    unique case (code)
      BL_CODE_8: beats_of = 5'h08;
      BL_CODE_16: beats_of = 5'h10;
      default: beats_of = 5'h04;
    endcase
  endfunction

  // read word: recognisable pattern of bank/row/column, column wraps in burst
  function automatic logic [31:0] word_of(input sar_rd_s e, input logic [4:0] n,
                                          input logic [4:0] beats);
    logic [11:0] msk;
    logic [11:0] cw;
    msk = {7'h00, beats - 5'h01};
    cw = (e.col & ~msk) | ((e.col + {7'h00, n}) & msk);
    word_of = e.mrr ? {24'h000000, e.mr_data} : {2'h0, e.bank, e.row, cw};
  endfunction

  // ***********************************************
  // pin synchronisers and command clock edges
  // ***********************************************
  sar_cabus_s pin_s1_r, pin_s2_r, pin_s3_r;
  logic [2:0] ck_sync_r;
  logic ck_lvl_r;
  logic ck_stable, ck_rise, ck_fall;

  // three stages each; all pins share the same delay so CA stays aligned to CK
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_s1_r <= '{cs_n: 1'b1, ca: 10'h000};
      pin_s2_r <= '{cs_n: 1'b1, ca: 10'h000};
      pin_s3_r <= '{cs_n: 1'b1, ca: 10'h000};
      ck_sync_r <= 3'h0;
    end
    else
    begin
      pin_s1_r <= '{cs_n: i_cs_n, ca: i_ca};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      ck_sync_r <= {ck_sync_r[1:0], i_ck};
    end
  end

  // a level change counts once stages two and three agree
  assign ck_stable = ck_sync_r[1] == ck_sync_r[2];
  assign ck_rise = ck_stable & ck_sync_r[2] & ~ck_lvl_r;
  assign ck_fall = ck_stable & ~ck_sync_r[2] & ck_lvl_r;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ck_lvl_r <= 1'b0;
    else if (ck_stable)
      ck_lvl_r <= ck_sync_r[2];
  end

  // ***********************************************
  // command capture and decode
  // ***********************************************
  logic [9:0] rise_ca_r;
  logic cmd_armed_r;
  logic cmd_ok;
  logic [9:0] fca;
  logic dec_act, dec_rd, dec_wr, dec_pre, dec_mrw, dec_mrr;
  logic [2:0] cmd_bank;
  logic [14:0] cmd_row;
  logic [11:0] cmd_col;
  logic [7:0] cmd_ma, cmd_op;
  logic soft_rst_r;

  // chip select is single rate, taken on the rise only
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rise_ca_r <= 10'h000;
      cmd_armed_r <= 1'b0;
    end
    else if (ck_rise)
    begin
      rise_ca_r <= pin_s3_r.ca;
      cmd_armed_r <= ~pin_s3_r.cs_n;
    end
    else if (ck_fall)
      cmd_armed_r <= 1'b0;
  end

  // a command completes at the fall, once both halves are in
  assign cmd_ok = ck_fall & cmd_armed_r;
  assign fca = pin_s3_r.ca;
  assign dec_act = cmd_ok & ~rise_ca_r[0] & rise_ca_r[1];
  assign dec_rd = cmd_ok & rise_ca_r[0] & ~rise_ca_r[1] & rise_ca_r[2];
  assign dec_wr = cmd_ok & rise_ca_r[0] & ~rise_ca_r[1] & ~rise_ca_r[2];
  assign dec_pre = cmd_ok & (rise_ca_r[3:0] == 4'hB);
  assign dec_mrw = cmd_ok & (rise_ca_r[3:0] == 4'h0);
  assign dec_mrr = cmd_ok & (rise_ca_r[3:0] == 4'h8);
  assign cmd_bank = bank_of(rise_ca_r[9:7]);
  assign cmd_row = {rise_ca_r[6:2], fca};
  assign cmd_col = {fca[9:1], rise_ca_r[6:5], 1'b0};
  assign cmd_ma = {fca[1:0], rise_ca_r[9:4]};
  assign cmd_op = fca[9:2];

  // ***********************************************
  // mode registers
  // ***********************************************
  logic [2:0] bl_code_r;
  logic [3:0] rl_code_r;
  logic [7:0] bank_mask_r, seg_mask_r;
  logic [3:0] rl_ck;
  logic [4:0] bl_beats;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bl_code_r <= RST_BL_CODE;
      rl_code_r <= RST_RL_CODE;
      bank_mask_r <= RST_MASK;
      seg_mask_r <= RST_MASK;
    end
    else if (soft_rst_r)
    begin
      bl_code_r <= RST_BL_CODE;
      rl_code_r <= RST_RL_CODE;
      bank_mask_r <= RST_MASK;
      seg_mask_r <= RST_MASK;
    end
    else if (dec_mrw)
    begin
      unique case (cmd_ma)
        MA_BURST_CFG:
          // reserved codes are dropped, old length stays
          if (cmd_op[2:0] inside {BL_CODE_4, BL_CODE_8, BL_CODE_16})
            bl_code_r <= cmd_op[2:0];
        MA_LATENCY_CFG:
          if (cmd_op[3:0] >= RL_CODE_MIN && cmd_op[3:0] <= RL_CODE_MAX)
            rl_code_r <= cmd_op[3:0];
        MA_BANK_MASK: bank_mask_r <= (NUM_BANKS == 4) ? {4'h0, cmd_op[3:0]} : cmd_op;
        MA_SEG_MASK: seg_mask_r <= cmd_op;
        default: ;
      endcase
    end
  end

  assign rl_ck = rl_code_r + RL_CODE_OFS;
  assign bl_beats = beats_of(bl_code_r);

  // data is ignored; the pulse clears state one cycle later
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= dec_mrw & (cmd_ma == MA_SOFT_RESET);
  end

  assign o_soft_reset = soft_rst_r;

  // ***********************************************
  // bank state
  // ***********************************************
  logic [7:0] open_r;
  logic [14:0] row_r [8];
  logic [3:0] pre_cnt_r [8];
  logic bank_busy;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      open_r <= 8'h00;
      for (int b = 0; b < 8; b++)
      begin
        row_r[b] <= 15'h0000;
        pre_cnt_r[b] <= 4'h0;
      end
    end
    else if (soft_rst_r)
    begin
      open_r <= 8'h00;
      for (int b = 0; b < 8; b++)
        pre_cnt_r[b] <= 4'h0;
    end
    else
    begin
      for (int b = 0; b < 8; b++)
        if (pre_cnt_r[b] != 4'h0)
          pre_cnt_r[b] <= pre_cnt_r[b] - 4'h1;
      if (dec_act && !bank_busy)
      begin
        open_r[cmd_bank] <= 1'b1;
        row_r[cmd_bank] <= cmd_row;
      end
      else if (dec_pre && rise_ca_r[4])
      begin
        open_r <= 8'h00;
        // eight-bank parts hold off longer after precharge-all
        for (int b = 0; b < 8; b++)
          pre_cnt_r[b] <= (NUM_BANKS == 8) ? RPAB_CYC : RPPB_CYC;
      end
      else if (dec_pre)
      begin
        open_r[cmd_bank] <= 1'b0;
        pre_cnt_r[cmd_bank] <= RPPB_CYC;
      end
    end
  end

  // reopening an open or still-precharging bank is flagged, not obeyed
  assign bank_busy = open_r[cmd_bank] | (pre_cnt_r[cmd_bank] != 4'h0);
  assign o_bank_open = open_r;

  // ***********************************************
  // read interrupt tracking and errors
  // ***********************************************
  logic [3:0] rd_gap_r;
  logic [4:0] last_half_r;
  logic last_ap_r;
  logic rd_live, bad_int, err_r;

  // counts command clocks since the last read, saturating
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_gap_r <= RST_RD_GAP;
      last_half_r <= 5'h00;
      last_ap_r <= 1'b0;
    end
    else if (dec_rd)
    begin
      rd_gap_r <= 4'h0;
      last_half_r <= {1'b0, bl_beats[4:1]};
      last_ap_r <= fca[0];
    end
    else if (ck_rise && rd_gap_r != RST_RD_GAP)
      rd_gap_r <= rd_gap_r + 4'h1;
  end

  assign rd_live = {1'b0, rd_gap_r} < last_half_r;
  // legal cut: burst 8/16, even gap, tCCD met, no autoprecharge
  assign bad_int = rd_live & ((bl_code_r == BL_CODE_4) | rd_gap_r[0]
                   | (rd_gap_r < T_CCD_CK) | last_ap_r | dec_wr);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      err_r <= 1'b0;
    else
      err_r <= (dec_act & bank_busy) | ((dec_rd | dec_wr) & ~open_r[cmd_bank])
               | ((dec_rd | dec_wr) & bad_int);
  end

  assign o_proto_err = err_r;

  // ***********************************************
  // read latency pipeline
  // ***********************************************
  sar_rd_s pipe_r [PIPE_DEPTH];
  logic [7:0] mr_val;

  always_comb
  begin
    unique case (cmd_ma)
      MA_CAL_A: mr_val = CAL_PATTERN_A;
      MA_CAL_B: mr_val = CAL_PATTERN_B;
      default: mr_val = 8'h00;
    endcase
  end

  // entry taken at the fall, one stage per command clock rise
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      for (int i = 0; i < PIPE_DEPTH; i++)
        pipe_r[i] <= '0;
    else if (soft_rst_r)
      for (int i = 0; i < PIPE_DEPTH; i++)
        pipe_r[i] <= '0;
    else if (ck_rise)
    begin
      pipe_r[0] <= '0;
      for (int i = 1; i < PIPE_DEPTH; i++)
        pipe_r[i] <= pipe_r[i - 1];
    end
    else if ((dec_rd && open_r[cmd_bank]) || dec_mrr)
    begin
      pipe_r[0].valid <= 1'b1;
      pipe_r[0].mrr <= dec_mrr;
      pipe_r[0].bank <= cmd_bank;
      pipe_r[0].row <= row_r[cmd_bank];
      pipe_r[0].col <= cmd_col;
      pipe_r[0].mr_data <= mr_val;
    end
  end

  // ***********************************************
  // burst engine and strobe
  // ***********************************************
  sar_rd_s cur_r, src;
  logic [4:0] beat_r, beats_r, n_beat, n_beats;
  logic act_r, act_nxt, pream_r, start, pre_due;
  logic [31:0] dq_r;
  logic dq_oe_r, dqs_r, dqs_oe_r;

  // entry reaching stage RL-1 starts its burst at this rise
  assign start = ck_rise & pipe_r[3'(rl_ck - 4'h1)].valid;
  assign pre_due = ck_rise & pipe_r[3'(rl_ck - 4'h2)].valid;

  // a new start simply replaces the running burst: gapless or cut short
  always_comb
  begin
    src = start ? pipe_r[3'(rl_ck - 4'h1)] : cur_r;
    n_beats = start ? (pipe_r[3'(rl_ck - 4'h1)].mrr ? 5'h04 : bl_beats) : beats_r;
    n_beat = start ? 5'h00 : beat_r + 5'h01;
    act_nxt = start | (act_r & (n_beat < beats_r));
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cur_r <= '0;
      beat_r <= 5'h00;
      beats_r <= 5'h04;
      act_r <= 1'b0;
      pream_r <= 1'b0;
      dq_r <= 32'h00000000;
      dq_oe_r <= 1'b0;
      dqs_r <= 1'b0;
      dqs_oe_r <= 1'b0;
    end
    else if (soft_rst_r)
    begin
      act_r <= 1'b0;
      pream_r <= 1'b0;
      dq_oe_r <= 1'b0;
      dqs_r <= 1'b0;
      dqs_oe_r <= 1'b0;
    end
    else if (ck_rise || ck_fall)
    begin
      cur_r <= src;
      beat_r <= n_beat;
      beats_r <= n_beats;
      act_r <= act_nxt;
      // preamble: strobe driven low the clock before the first beat
      if (ck_rise)
        pream_r <= pre_due & ~act_nxt;
      dq_r <= word_of(src, n_beat, n_beats);
      dq_oe_r <= act_nxt;
      dqs_r <= act_nxt & ~n_beat[0];
      dqs_oe_r <= act_nxt | (ck_rise ? (pre_due & ~act_nxt) : pream_r);
    end
  end

  assign o_dq_out = dq_r;
  assign o_dq_oe = dq_oe_r;
  assign o_dqs_out = dqs_r;
  assign o_dqs_oe = dqs_oe_r;

  // ***********************************************
  // partial array self-refresh masking
  // ***********************************************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_sr_blocked <= 1'b0;
    else
      o_sr_blocked <= bank_mask_r[bank_of(i_sr_bank)]
                      | seg_mask_r[i_sr_row[13:11]];
  end

endmodule
`default_nettype wire

// ### verif/sar_ctl_model.sv
`default_nettype none
module sar_ctl_model
(
  // system clock
  input wire logic i_clk,
  // command clock and command/address pins
  output logic o_ck,
  output logic o_cs_n,
  output logic [9:0] o_ca
);
  timeunit 1ns;
  timeprecision 1ps;

  int rises = 0;

  // ck rests low between frames
  initial
  begin
    o_ck = 1'b0;
    o_cs_n = 1'b1;
    o_ca = 10'h000;
  end

  // one ck cycle, 16 i_clk; each half of ca held 4 i_clk around its edge
  task automatic cmd(input logic cs, input logic [9:0] r, input logic [9:0] f);
    @(posedge i_clk) o_cs_n <= cs;
    o_ca <= r;
    repeat (4) @(posedge i_clk);
    o_ck <= 1'b1;
    rises++;
    repeat (4) @(posedge i_clk);
    o_ca <= f;
    repeat (4) @(posedge i_clk);
    o_ck <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  // deselected cycles; ca keeps toggling so nothing stale looks valid
  task automatic nop(input int n);
    repeat (n) cmd(1'b1, 10'h2AA, 10'h155);
  endtask

  task automatic act(input logic [2:0] b, input logic [14:0] row);
    cmd(1'b0, {b, row[14:10], 2'b10}, row[9:0]);
  endtask

  // column command: w picks a write, ap asks for auto-precharge
  task automatic colc(input logic w, input logic ap, input logic [2:0] b, input logic [11:0] c);
    cmd(1'b0, {b, c[2:1], 2'b00, ~w, 2'b01}, {c[11:3], ap});
  endtask

  // plain read, no auto-precharge, so it may be cut short
  task automatic rd(input logic [2:0] b, input logic [11:0] c);
    colc(1'b0, 1'b0, b, c);
  endtask

  task automatic pre(input logic [2:0] b, input logic ab);
    cmd(1'b0, {b, 2'b00, ab, 4'b1011}, 10'h000);
  endtask

  task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
    cmd(1'b0, {ma[5:0], 4'b0000}, {op, ma[7:6]});
  endtask

  task automatic mrr(input logic [7:0] ma);
    cmd(1'b0, {ma[5:0], 4'b1000}, {8'h00, ma[7:6]});
  endtask
endmodule
`default_nettype wire

// ### verif/sar_device_assertions.sv
`default_nettype none
module sar_device_assertions
#(
  parameter int NUM_BANKS = 8
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ck,
  // data side
  input wire logic [31:0] o_dq_out,
  input wire logic o_dq_oe,
  input wire logic o_dqs_out,
  input wire logic o_dqs_oe,
  // status
  input wire logic [7:0] o_bank_open,
  input wire logic o_proto_err,
  input wire logic o_soft_reset
);
  // ****************************
  // cycles since the last ck pin edge
  // ****************************
  logic ck_q;
  logic [3:0] ck_age_r;
  logic [3:0] ck_age_nxt;

  // saturates so a stopped ck never wraps back into range
  assign ck_age_nxt = (ck_age_r == 4'hF) ? ck_age_r : ck_age_r + 4'h1;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ck_q <= 1'b0;
      ck_age_r <= 4'hF;
    end
    else
    begin
      ck_q <= i_ck;
      ck_age_r <= (i_ck != ck_q) ? 4'h0 : ck_age_nxt;
    end
  end

  // ****************************
  // properties
  // ****************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_pre_low;
    (!o_dq_oe && !o_dqs_out) [*8];
  endsequence
  sequence s_first_beat;
    $rose(o_dq_oe) && o_dqs_out;
  endsequence

  preamble_a:
    assert property ($rose(o_dqs_oe) |-> s_pre_low ##[1:12] s_first_beat)
    else $error("strobe preamble wrong");
  strobe_cover_a:
    assert property (o_dq_oe |-> o_dqs_oe)
    else $error("data driven without strobe");
  strobe_pace_a:
    assert property (o_dqs_oe && $past(o_dqs_oe) && $changed(o_dqs_out)
      |-> ck_age_r inside {[1:6]})
    else $error("strobe edge off ck");
  data_hold_a:
    assert property (o_dq_oe && $past(o_dq_oe) && $stable(o_dqs_out) |-> $stable(o_dq_out))
    else $error("data moved between strobe edges");
  strobe_drop_a:
    assert property ($fell(o_dq_oe) |-> $fell(o_dqs_oe) || (o_dqs_oe && !o_dqs_out))
    else $error("strobe outlives data");
  bank_step_a:
    assert property ($changed(o_bank_open) |-> ck_age_r inside {[1:7]})
    else $error("bank state moved off ck");
  one_bank_a:
    assert property ($changed(o_bank_open) |-> $onehot0(o_bank_open & ~$past(o_bank_open)))
    else $error("several banks opened at once");
  bank_range_a:
    assert property ((o_bank_open >> NUM_BANKS) == 8'h00)
    else $error("absent bank open");
  soft_reset_a:
    assert property (o_soft_reset |=> !o_soft_reset ##[0:1] (o_bank_open == 8'h00))
    else $error("mode reset left banks open");
  err_pulse_a:
    assert property (o_proto_err |=> !o_proto_err)
    else $error("error flag not a pulse");
endmodule

bind sar_device sar_device_assertions #(.NUM_BANKS(NUM_BANKS)) u_chk (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_ck(i_ck),
  .o_dq_out(o_dq_out),
  .o_dq_oe(o_dq_oe),
  .o_dqs_out(o_dqs_out),
  .o_dqs_oe(o_dqs_oe),
  .o_bank_open(o_bank_open),
  .o_proto_err(o_proto_err),
  .o_soft_reset(o_soft_reset)
);
`default_nettype wire

// ### verif/sar_device_tb.sv
`default_nettype none
module sar_device_tb
  import sar_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [2:0] sr_bank;
  logic [14:0] sr_row;
  logic ck, cs_n, dq_oe, dqs, dqs_oe, sr_blk, err, srst;
  logic [9:0] ca;
  logic [31:0] dq;
  logic [7:0] bopen;
  logic oe_q = 1'b0;
  logic dqs_q = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int errs = 0;
  int resets = 0;
  int rl = 3;
  int bl_lg = 2;
  logic [31:0] exp_dq[$];
  int exp_rise[$];
  logic [14:0] row_of[8];
  logic [31:0] rnd = 32'h4F6DCD7C;

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  // calibration values are arbitrary
  sar_device #(.NUM_BANKS(8), .CAL_PATTERN_A(8'hA6), .CAL_PATTERN_B(8'h3C)) dut_u (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ck(ck), .i_cs_n(cs_n), .i_ca(ca),
    .o_dq_out(dq), .o_dq_oe(dq_oe), .o_dqs_out(dqs), .o_dqs_oe(dqs_oe),
    .i_sr_bank(sr_bank), .i_sr_row(sr_row), .o_sr_blocked(sr_blk),
    .o_bank_open(bopen), .o_proto_err(err), .o_soft_reset(srst)
  );

  sar_ctl_model u_ctl (.i_clk(i_clk), .o_ck(ck), .o_cs_n(cs_n), .o_ca(ca));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // note n beats: low bits of the column wrap inside the burst
  task automatic note(input logic [31:0] hi, input logic [11:0] c, input logic [11:0] m,
                      input int n);
    int t;
    t = u_ctl.rises + 1 + rl;
    for (int k = 0; k < n; k++)
    begin
      exp_dq.push_back(hi | 32'((c & ~m) | ((c + 12'(k)) & m)));
      exp_rise.push_back(t + k / 2);
    end
  endtask

  task automatic act(input logic [2:0] b);
    rnd = lfsr(rnd);
    row_of[b] = rnd[30:16];
    u_ctl.act(b, row_of[b]); // few activates, no per-bank refresh
  endtask

  task automatic rdx(input logic ap, input logic [2:0] b, input int n);
    logic [11:0] c;
    rnd = lfsr(rnd);
    c = rnd[11:0] & 12'hFFE;
    note({2'b00, b, row_of[b], 12'h000}, c, 12'((1 << bl_lg) - 1), n);
    u_ctl.colc(1'b0, ap, b, c);
  endtask

  task automatic rd(input logic [2:0] b, input int n);
    rdx(1'b0, b, n);
  endtask

  task automatic mrr(input logic [7:0] ma, input logic [7:0] v);
    note({24'h000000, v}, 12'h000, 12'h000, 4);
    u_ctl.mrr(ma);
    u_ctl.nop(1);
  endtask

  task automatic drain(input int n);
    u_ctl.nop(n);
    chk("notes left", 32'h0, 32'(exp_dq.size()));
  endtask

  task automatic sr_query(input logic [7:0] bm, input logic [7:0] sm);
    rnd = lfsr(rnd);
    @(posedge i_clk);
    sr_bank <= rnd[2:0];
    sr_row <= rnd[17:3];
    repeat (2) @(posedge i_clk);
    chk("blocked", {31'h0, bm[rnd[2:0]] | sm[rnd[16:14]]}, {31'h0, sr_blk});
  endtask

  // each new beat (oe rise or strobe flip) takes the oldest note
  always @(posedge i_clk)
  begin
    if (dq_oe === 1'b1 && (oe_q !== 1'b1 || dqs !== dqs_q))
    begin
      if (exp_dq.size() == 0)
        chk("spare beat", 32'h0, 32'h1);
      else
      begin
        chk("beat data", exp_dq.pop_front(), dq);
        chk("beat rise", 32'(exp_rise.pop_front()), 32'(u_ctl.rises));
      end
    end
    if (err === 1'b1)
      errs++;
    if (srst === 1'b1)
      resets++;
    oe_q <= dq_oe;
    dqs_q <= dqs;
  end

  // hang guard, far above the few thousand cycles needed
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    logic [7:0] bm;
    logic [7:0] sm;
    sr_bank <= rnd[2:0];
    sr_row <= rnd[17:3];
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (6) @(posedge i_clk);
    rnd = lfsr(rnd);
    bm = rnd[7:0];
    sm = rnd[15:8];
    u_ctl.mrw(MA_BANK_MASK, bm);
    u_ctl.mrw(MA_SEG_MASK, sm);
    u_ctl.nop(1);
    for (int i = 0; i < 24; i++)
      sr_query(bm, sm);
    $display("mask test done");
    mrr(MA_CAL_A, 8'hA6);
    mrr(MA_CAL_B, 8'h3C);
    mrr(MA_SEG_MASK, 8'h00);
    drain(6);
    $display("mode read test done");
    act(3'h3);
    act(3'h6);
    u_ctl.nop(1);
    chk("open banks", 32'h48, 32'(bopen));
    u_ctl.act(3'h6, 15'h0000);
    rd(3'h3, 4);
    u_ctl.nop(1);
    rd(3'h6, 4);
    u_ctl.nop(1);
    rd(3'h1, 0);
    drain(6);
    chk("errors", 32'h2, 32'(errs));
    chk("open banks", 32'h48, 32'(bopen));
    $display("bank test done");
    u_ctl.mrw(MA_BURST_CFG, {5'h00, BL_CODE_8});
    u_ctl.mrw(MA_BURST_CFG, 8'h07);
    u_ctl.mrw(MA_LATENCY_CFG, 8'h05);
    bl_lg = 3;
    rl = 7;
    rd(3'h6, 4);
    u_ctl.nop(1);
    rd(3'h3, 8);
    u_ctl.nop(3);
    rd(3'h6, 8);
    drain(12);
    u_ctl.mrw(MA_BURST_CFG, {5'h00, BL_CODE_16});
    bl_lg = 4;
    rd(3'h3, 16);
    u_ctl.nop(7);
    rd(3'h6, 16);
    drain(16);
    chk("errors", 32'h2, 32'(errs));
    // cut of an auto-precharge read, odd-gap cut, write into a live read
    rdx(1'b1, 3'h3, 4);
    u_ctl.nop(1);
    rd(3'h6, 6);
    u_ctl.nop(2);
    rd(3'h3, 16);
    u_ctl.nop(1);
    u_ctl.colc(1'b1, 1'b0, 3'h6, 12'h000);
    drain(16);
    chk("errors", 32'h5, 32'(errs));
    $display("burst test done");
    u_ctl.pre(3'h3, 1'b0);
    u_ctl.nop(1);
    chk("open banks", 32'h40, 32'(bopen));
    u_ctl.pre(3'h0, 1'b1);
    u_ctl.nop(1);
    chk("open banks", 32'h00, 32'(bopen));
    act(3'h6);
    u_ctl.nop(1);
    chk("open banks", 32'h40, 32'(bopen));
    u_ctl.mrw(MA_SOFT_RESET, rnd[7:0]);
    u_ctl.nop(1);
    chk("open banks", 32'h00, 32'(bopen));
    chk("resets", 32'h1, 32'(resets));
    bl_lg = 2;
    rl = 3;
    act(3'h2);
    u_ctl.nop(1);
    rd(3'h2, 2);
    rd(3'h2, 4);
    drain(6);
    chk("errors", 32'h6, 32'(errs));
    sr_query(8'h00, 8'h00);
    $display("precharge and reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
